// >>> rspc_pkg.sv
// package of constants and types for the reset and standby pin controller
package rspc_pkg;
  // ---------------------------------------------------------------------------
  // clock, timing and port count
  // ---------------------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned NPORT          = 31;
  localparam int unsigned STRETCH_MIN    = 1920;
  localparam int unsigned STRETCH_MAX    = 2048;
  localparam int unsigned STRETCH_W      = 12;
  localparam int unsigned RES_MIN_US     = 200;
  localparam int unsigned RES_MIN_CYC    = RES_MIN_US * CLK_MHZ;
  localparam int unsigned FILT_CYC       = 4;
  localparam int unsigned FILT_W         = 3;
  localparam int unsigned TCYC_DIV       = 4;
  localparam int unsigned DIV_W          = 2;
  localparam int unsigned RST_HOLD_CYC   = 4;
  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0] SP_RST         = 16'h0000;
  localparam logic [7:0]  SFR_RST        = 8'h00;
  localparam logic [15:0] PC_START_DEF   = 16'h0000;
  localparam logic [1:0]  CLK_SEL_RC     = 2'h0;

  typedef enum logic [1:0] {
    RSPC_NORMAL = 2'b00,
    RSPC_HALT   = 2'b01,
    RSPC_HOLD   = 2'b11
  } rspc_mode_t;
endpackage

// >>> rspc_top.sv
// reset sequencer and standby pin-state control
// Notes on behaviour
// [R1] general port direction and pull-up follow software in normal, halt and hold
// [R2] software discharge on watchdog pin stretched to turn off 1920..2048 cycles
// [R3] halt/hold: watchdog pin input, pull-up off, discharge off, stretch cancelled
// [R4] after hold, watchdog pin returns to software control as in normal mode
// [R5] reset pin held low 200 us or longer always resets the device
// [R6] short low pulses on reset pin may also reset; not reliably ignored
// [R7] watchdog runaway is a second reset source beside the reset pin
// [R8] internal initialisation uses a reset synchronised to the system clock
// [R9] any reset selects internal rc clock and initialises at once
// [R10] software enables main oscillator, waits, then selects main clock
// [R11] reset loads program counter with configured start address
// [R12] reset loads every special function register with its initial value
// [R13] reset clears stack pointer to zero
// [R14] reset never touches data ram
// [R15] while in reset all general port pins are inputs with pull-up off
`timescale 1ns/1ps
`default_nettype none
module rspc_top
  import rspc_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  ext_reset_pin_n_in,
  input  wire logic                  runaway_in,
  input  wire logic                  runaway_reset_en_in,
  input  wire rspc_pkg::rspc_mode_t  mode_in,
  input  wire logic [15:0]           pc_start_in,
  input  wire logic [NPORT-1:0]      port_dir_in,
  input  wire logic [NPORT-1:0]      port_pu_in,
  input  wire logic                  wd_pin_dir_in,
  input  wire logic                  wd_pin_pu_in,
  input  wire logic                  wd_discharge_in,
  output logic                       sys_reset_out,
  output logic [1:0]                 clk_sel_out,
  output logic                       clk_sel_rc_out,
  output logic [15:0]                pc_load_out,
  output logic                       pc_load_en_out,
  output logic [15:0]                sp_load_out,
  output logic [7:0]                 sfr_init_out,
  output logic                       ram_write_block_out,
  output logic [NPORT-1:0]           port_dir_out,
  output logic [NPORT-1:0]           port_pu_out,
  output logic                       wd_pin_dir_out,
  output logic                       wd_pin_pu_out,
  output logic                       wd_discharge_out
);
  import rspc_pkg::*;

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  logic sync_res1_r;
  logic sync_res1_nxt;
  logic sync_res2_r;
  logic sync_res2_nxt;
  logic sync_wd1_r;
  logic sync_wd1_nxt;
  logic sync_wd2_r;
  logic sync_wd2_nxt;

  always_comb begin
    sync_res1_nxt = ext_reset_pin_n_in;
    sync_res2_nxt = sync_res1_r;
    sync_wd1_nxt  = runaway_in;
    sync_wd2_nxt  = sync_wd1_r;
    if (rst_in) begin
      sync_res1_nxt = 1'b1;
      sync_res2_nxt = 1'b1;
      sync_wd1_nxt  = 1'b0;
      sync_wd2_nxt  = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    sync_res1_r <= sync_res1_nxt;
    sync_res2_r <= sync_res2_nxt;
    sync_wd1_r  <= sync_wd1_nxt;
    sync_wd2_r  <= sync_wd2_nxt;
  end

  // ---------------------------------------------------------------------------
  // reset sources and synchronous reset stretch
  // ---------------------------------------------------------------------------
  // the glitch filter is far shorter than the guaranteed minimum, so pulses
  // well under it still reset; long holds always do
  // the hold counter keeps the internal reset up a few cycles after the
  // last source goes away, so a bouncing pin cannot chop it into slivers
  logic [FILT_W-1:0] filt_r;
  logic [FILT_W-1:0] filt_nxt;
  logic [FILT_W-1:0] hold_r;
  logic [FILT_W-1:0] hold_nxt;
  logic              sys_rst_r;
  logic              sys_rst_nxt;
  logic              src_rst;

  always_comb begin
    filt_nxt = '0;
    if (!sync_res2_r) begin
      filt_nxt = (filt_r == FILT_W'(FILT_CYC)) ? filt_r : filt_r + 1'b1; // [R6]
    end
    src_rst = (filt_r == FILT_W'(FILT_CYC))                              // [R5]
            | (sync_wd2_r & runaway_reset_en_in);                        // [R7]
    hold_nxt = hold_r;
    sys_rst_nxt = sys_rst_r;
    if (src_rst) begin
      hold_nxt    = FILT_W'(RST_HOLD_CYC);
      sys_rst_nxt = 1'b1;
    end else if (hold_r != '0) begin
      hold_nxt = hold_r - 1'b1;
    end else begin
      sys_rst_nxt = 1'b0;
    end
    if (rst_in) begin
      filt_nxt    = '0;
      hold_nxt    = FILT_W'(RST_HOLD_CYC);
      sys_rst_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    filt_r    <= filt_nxt;
    hold_r    <= hold_nxt;
    sys_rst_r <= sys_rst_nxt;  // [R8]
  end

  // ---------------------------------------------------------------------------
  // initialisation values and clock select
  // ---------------------------------------------------------------------------
  logic [1:0]  clk_sel_r;
  logic [1:0]  clk_sel_nxt;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic        pc_en_r;
  logic        pc_en_nxt;

  always_comb begin
    clk_sel_nxt = clk_sel_r;
    pc_nxt      = pc_r;
    pc_en_nxt   = 1'b0;
    if (sys_rst_nxt) begin
      clk_sel_nxt = CLK_SEL_RC;  // [R9]
      pc_nxt      = pc_start_in; // [R11]
      pc_en_nxt   = 1'b1;
    end
    if (rst_in) begin
      clk_sel_nxt = CLK_SEL_RC;
      pc_nxt      = PC_START_DEF;
      pc_en_nxt   = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    clk_sel_r <= clk_sel_nxt;
    pc_r      <= pc_nxt;
    pc_en_r   <= pc_en_nxt;
  end

  // main clock selection is left to software once it has stabilised the
  // oscillator; this block only forces the rc source
  assign clk_sel_out         = clk_sel_r;                  // [R10]
  assign sys_reset_out       = sys_rst_r;
  assign pc_load_out         = pc_r;
  assign pc_load_en_out      = pc_en_r;

  // ---------------------------------------------------------------------------
  // registered constants and clock status
  // ---------------------------------------------------------------------------
  // constants leave through flops like every other output; they reload each
  // cycle, so an upset flop heals on the next edge
  logic [15:0] sp_r;
  logic [15:0] sp_nxt;
  logic [7:0]  sfr_r;
  logic [7:0]  sfr_nxt;
  logic        ram_blk_r;
  logic        ram_blk_nxt;
  logic        rc_sel_r;
  logic        rc_sel_nxt;

  always_comb begin
    sp_nxt      = SP_RST;                          // [R13]
    sfr_nxt     = SFR_RST;                         // [R12]
    ram_blk_nxt = 1'b0;                            // [R14]
    rc_sel_nxt  = (clk_sel_nxt == CLK_SEL_RC);     // [R9]
  end

  always_ff @(posedge clk_in) begin
    sp_r      <= sp_nxt;
    sfr_r     <= sfr_nxt;
    ram_blk_r <= ram_blk_nxt;
    rc_sel_r  <= rc_sel_nxt;
  end

  // reset never reaches data ram; this path only ever reports no action
  assign sp_load_out         = sp_r;
  assign sfr_init_out        = sfr_r;
  assign ram_write_block_out = ram_blk_r;
  assign clk_sel_rc_out      = rc_sel_r;

  // ---------------------------------------------------------------------------
  // instruction cycle divider and discharge stretcher
  // ---------------------------------------------------------------------------
  logic [DIV_W-1:0]     div_r;
  logic [DIV_W-1:0]     div_nxt;
  logic                 tcyc;
  logic [STRETCH_W-1:0] str_r;
  logic [STRETCH_W-1:0] str_nxt;
  logic                 str_on_r;
  logic                 str_on_nxt;
  logic                 standby;

  // free-running divider; its phase against a request is unknown, which is
  // why the stretch spends one extra tick at zero to keep the short end of the window
  always_comb begin
    div_nxt = div_r + 1'b1;
    tcyc    = (div_r == DIV_W'(TCYC_DIV - 1));
    if (rst_in) begin
      div_nxt = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    div_r <= div_nxt;
  end

  always_comb begin
    standby    = (mode_in != RSPC_NORMAL);
    str_nxt    = str_r;
    str_on_nxt = str_on_r;
    if (wd_discharge_in) begin
      str_nxt    = STRETCH_W'(STRETCH_MIN);      // [R2]
      str_on_nxt = 1'b1;
    end else if (str_on_r && tcyc) begin
      if (str_r == '0) begin
        str_on_nxt = 1'b0;
      end else begin
        str_nxt = str_r - 1'b1;
      end
    end
    if (standby || sys_rst_r || rst_in) begin
      str_nxt    = '0;                             // [R3]
      str_on_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    str_r    <= str_nxt;
    str_on_r <= str_on_nxt;
  end

  // ---------------------------------------------------------------------------
  // pin state outputs
  // ---------------------------------------------------------------------------
  logic [NPORT-1:0] pdir_r;
  logic [NPORT-1:0] pdir_nxt;
  logic [NPORT-1:0] ppu_r;
  logic [NPORT-1:0] ppu_nxt;
  logic             wdir_r;
  logic             wdir_nxt;
  logic             wpu_r;
  logic             wpu_nxt;
  logic             wdis_r;
  logic             wdis_nxt;

  // general pins ignore halt and hold entirely; only reset overrides them
  always_comb begin
    pdir_nxt = port_dir_in;                     // [R1]
    ppu_nxt  = port_pu_in;
    if (sys_rst_nxt || rst_in) begin
      pdir_nxt = '0;                            // [R15]
      ppu_nxt  = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    pdir_r <= pdir_nxt;
    ppu_r  <= ppu_nxt;
  end

  // discharge follows the stretcher state of the same edge, so the pin and
  // the counter disagree only on the first cycle of a pin or runaway reset
  always_comb begin
    wdir_nxt = wd_pin_dir_in;                   // [R4]
    wpu_nxt  = wd_pin_pu_in;
    wdis_nxt = str_on_nxt;
    if (standby) begin
      wdir_nxt = 1'b0;                          // [R3]
      wpu_nxt  = 1'b0;
      wdis_nxt = 1'b0;
    end
    if (sys_rst_nxt || rst_in) begin
      wdir_nxt = 1'b0;                          // [R15]
      wpu_nxt  = 1'b0;
      wdis_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    wdir_r <= wdir_nxt;
    wpu_r  <= wpu_nxt;
    wdis_r <= wdis_nxt;
  end

  assign port_dir_out     = pdir_r;
  assign port_pu_out      = ppu_r;
  assign wd_pin_dir_out   = wdir_r;
  assign wd_pin_pu_out    = wpu_r;
  assign wd_discharge_out = wdis_r;
endmodule
`default_nettype wire

// >>> rspc_rc_model.sv
// behavioural model of the external reset switch and watchdog rc network
`timescale 1ns/1ps
`default_nettype none
module rspc_rc_model #(
  parameter int CHARGE_CYC = 300
) (
  input  wire logic clk_in,
  input  wire logic hold_low_in,
  input  wire logic discharge_in,
  output logic      reset_pin_n_out,
  output logic      runaway_out
);
  int charge_r = 0;
  // pulled up: the pin is low only while the switch is closed
  assign reset_pin_n_out = !hold_low_in;
  // capacitor charges whenever the transistor is off
  always @(posedge clk_in) charge_r <= discharge_in ? 0 : charge_r + 1;
  assign runaway_out = charge_r >= CHARGE_CYC;
endmodule
`default_nettype wire

// >>> rspc_checker.sv
// concurrent checks on the reset and standby pin controller ports
`timescale 1ns/1ps
`default_nettype none
module rspc_checker
  import rspc_pkg::*;
(
  input wire logic                 clk_in,
  input wire logic                 rst_in,
  input wire logic                 ext_reset_pin_n_in,
  input wire logic                 runaway_in,
  input wire logic                 runaway_reset_en_in,
  input wire rspc_pkg::rspc_mode_t mode_in,
  input wire logic [15:0]          pc_start_in,
  input wire logic                 wd_discharge_in,
  input wire logic                 sys_reset_out,
  input wire logic [1:0]           clk_sel_out,
  input wire logic                 clk_sel_rc_out,
  input wire logic [15:0]          pc_load_out,
  input wire logic                 pc_load_en_out,
  input wire logic [15:0]          sp_load_out,
  input wire logic [7:0]           sfr_init_out,
  input wire logic                 ram_write_block_out,
  input wire logic [NPORT-1:0]     port_dir_out,
  input wire logic [NPORT-1:0]     port_pu_out,
  input wire logic                 wd_pin_dir_out,
  input wire logic                 wd_pin_pu_out,
  input wire logic                 wd_discharge_out
);
  logic [13:0] on_r;
  logic [13:0] on_nxt;
  // cycles since the last discharge request; only read when the output falls
  always_comb on_nxt = wd_discharge_in ? 14'h0 : on_r + 14'h1;
  always_ff @(posedge clk_in) on_r <= on_nxt;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  init_consts_a: assert property (sp_load_out == SP_RST &&
    sfr_init_out == SFR_RST && !ram_write_block_out) else $error("init constants wrong");
  reset_pins_a: assert property (disable iff (1'b0) sys_reset_out |->
    !port_dir_out && !port_pu_out) else $error("pins not inputs in reset");
  rc_clock_a: assert property (sys_reset_out |->
    clk_sel_out == CLK_SEL_RC && clk_sel_rc_out) else $error("rc clock not selected");
  pc_load_a: assert property (sys_reset_out && $past(sys_reset_out) && !$past(rst_in) |->
    pc_load_en_out && pc_load_out == pc_start_in) else $error("start address not loaded");
  pin_reset_a: assert property (!ext_reset_pin_n_in [*8] |-> ##[0:3] sys_reset_out)
    else $error("reset pin ignored");
  runaway_reset_a: assert property ((runaway_in && runaway_reset_en_in) [*4] |->
    ##[0:2] sys_reset_out) else $error("runaway ignored");
  stretch_start_a: assert property (wd_discharge_in && mode_in == RSPC_NORMAL &&
    !sys_reset_out |=> wd_discharge_out) else $error("discharge not started");
  stretch_len_a: assert property ($fell(wd_discharge_out) && !$past(sys_reset_out) &&
    !sys_reset_out && mode_in == RSPC_NORMAL && $past(mode_in) == RSPC_NORMAL |->
    on_r >= 14'h1e00 && on_r <= 14'h2000)
    else $error("stretch length wrong");
  standby_pin_a: assert property (mode_in != RSPC_NORMAL |=> !wd_discharge_out &&
    !wd_pin_dir_out && !wd_pin_pu_out) else $error("watchdog pin active in standby");
  cover property (!ext_reset_pin_n_in ##1 sys_reset_out);
  cover property (runaway_in && runaway_reset_en_in ##1 sys_reset_out);
  cover property ($fell(wd_discharge_out));
endmodule
bind rspc_top rspc_checker u_chk (.*);
`default_nettype wire

// >>> tb_rspc_top.sv
// self-checking testbench for the reset and standby pin controller
`timescale 1ns/1ps
`default_nettype none
module tb_rspc_top;
  import rspc_pkg::*;
  logic clk_in = 0, rst_in = 1, hold_low = 0, run_en = 0, wd_dir = 1, wd_pu = 1, wd_req = 0;
  logic pin_n, runaway, sys_rst, rc_sel, pc_en, wd_dir_o, wd_pu_o, wd_dis, ram_blk;
  logic [NPORT-1:0] dir_in = '1, pu_in = '1, dir_o, pu_o;
  logic [15:0]      pc_start = 16'h1234, pc_ld, sp_ld;
  logic [7:0]       sfr;
  logic [1:0]       clk_sel;
  rspc_mode_t       mode = RSPC_NORMAL;
  int miscompares = 0, checked = 0;
  always #2 clk_in = ~clk_in;
  rspc_rc_model u_rc (.clk_in(clk_in), .hold_low_in(hold_low), .discharge_in(wd_dis),
    .reset_pin_n_out(pin_n), .runaway_out(runaway));
  rspc_top uut (.clk_in(clk_in), .rst_in(rst_in), .ext_reset_pin_n_in(pin_n),
    .runaway_in(runaway), .runaway_reset_en_in(run_en), .mode_in(mode), .pc_start_in(pc_start),
    .port_dir_in(dir_in), .port_pu_in(pu_in), .wd_pin_dir_in(wd_dir), .wd_pin_pu_in(wd_pu),
    .wd_discharge_in(wd_req), .sys_reset_out(sys_rst), .clk_sel_out(clk_sel),
    .clk_sel_rc_out(rc_sel), .pc_load_out(pc_ld), .pc_load_en_out(pc_en), .sp_load_out(sp_ld),
    .sfr_init_out(sfr), .ram_write_block_out(ram_blk), .port_dir_out(dir_o),
    .port_pu_out(pu_o), .wd_pin_dir_out(wd_dir_o), .wd_pin_pu_out(wd_pu_o),
    .wd_discharge_out(wd_dis));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // bounded wait for the synchronised reset to drop
  task automatic wait_run();
    for (int i = 0; i < 100 && sys_rst !== 1'b0; i++) cyc(1);
  endtask
  task automatic t_in_reset();
    chk("sp", SP_RST, sp_ld);
    chk("sfr", SFR_RST, sfr);
    chk("ram block", 0, ram_blk);
    chk("clock select", CLK_SEL_RC, clk_sel);
    chk("port dir", 0, dir_o);
    chk("port pullup", 0, pu_o);
    chk("rc select", 1, rc_sel);
    chk("sys reset", 1, sys_rst);
  endtask
  // normal, halt, hold, then back to normal
  task automatic t_ports();
    rspc_mode_t m[3] = '{RSPC_NORMAL, RSPC_HALT, RSPC_HOLD};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_in);
      mode <= m[i % 3];
      dir_in <= ~dir_in;
      pu_in <= {pu_in[NPORT-2:0], ~pu_in[NPORT-1]};
      cyc(2);
      chk("port dir", dir_in, dir_o);
      chk("port pullup", pu_in, pu_o);
      chk("wd pin dir", mode == RSPC_NORMAL, wd_dir_o);
      chk("wd pin pullup", mode == RSPC_NORMAL, wd_pu_o);
      chk("clock select", CLK_SEL_RC, clk_sel);
    end
  endtask
  task automatic t_stretch();
    int n = 0;
    @(posedge clk_in) wd_req <= 1;
    @(posedge clk_in) wd_req <= 0;
    cyc(1);
    while (wd_dis === 1'b1 && n < 9000) begin
      cyc(1);
      n++;
    end
    chk("stretch ok", 1, n >= 7679 && n <= 8191);
    @(posedge clk_in) wd_req <= 1;
    @(posedge clk_in) wd_req <= 0;
    cyc(100);
    @(posedge clk_in) mode <= RSPC_HALT;
    cyc(2);
    chk("discharge in halt", 0, wd_dis);
    @(posedge clk_in) mode <= RSPC_NORMAL;
    cyc(2);
    chk("discharge after halt", 0, wd_dis);
  endtask
  task automatic t_pin_reset();
    @(posedge clk_in) hold_low <= 1;
    cyc(RES_MIN_CYC);
    chk("pin reset", 1, sys_rst);
    chk("pc load", {1'b1, pc_start}, {pc_en, pc_ld});
    chk("port dir", 0, dir_o);
    @(posedge clk_in) hold_low <= 0;
    wait_run();
    chk("pin release", 0, sys_rst);
  endtask
  // a pulse far below the guaranteed minimum still resets this design
  task automatic t_short_pulse();
    @(posedge clk_in) hold_low <= 1;
    cyc(10);
    chk("short pulse reset", 1, sys_rst);
    @(posedge clk_in) hold_low <= 0;
    wait_run();
    chk("short pulse release", 0, sys_rst);
  endtask
  task automatic t_runaway();
    cyc(300);
    @(posedge clk_in) run_en <= 1;
    cyc(12);
    chk("runaway reset", 1, sys_rst);
    chk("runaway clock", CLK_SEL_RC, clk_sel);
    @(posedge clk_in) run_en <= 0;
    wait_run();
    chk("runaway release", 0, sys_rst);
  endtask
  task automatic complete_run();
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    cyc(20);
    t_in_reset();
    @(posedge clk_in) rst_in <= 0;
    wait_run();
    t_ports();
    t_stretch();
    t_pin_reset();
    t_short_pulse();
    t_runaway();
    complete_run();
  end
  // about 58000 cycles are expected
  initial begin
    #360000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
